// ===== pkg/fsc_pkg.sv
/*
 * Constants for the receive-channel frame sync, control and status block.
 * Assumes a single 125 MHz system clock and 12-bit received words.
 */
package fsc_pkg;
   // SPI instruction codes, sent MSB first.
   localparam logic [7:0] OP_CTRL_WR = 8'h62;
   localparam logic [7:0] OP_CTRL_RD = 8'hE2;
   localparam logic [7:0] OP_STAT_RD = 8'hE6;
   localparam int SPI_BITS = 8;

   // Control register fields.
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int CTRL_USED_W = 4;
   localparam int CB_FLUSH = 3;
   localparam int CB_RELAXED = 2;
   localparam int CB_RAW = 1;
   localparam int CB_TEST = 0;

   // Status register fields.
   localparam int SB_LOCK = 7;
   localparam int SB_ID_HI = 6;
   localparam int SB_ID_LO = 5;
   localparam int SB_FULL = 4;
   localparam int SB_HALF = 3;
   localparam int SB_EMPTY = 2;
   localparam int SB_OVF = 1;

   // Receive word and queue geometry.
   localparam int WORD_W = 12;
   localparam int QUEUE_DEPTH = 32;
   localparam int QUEUE_HALF = 16;

   // Subframe sync marks, octal 1107, 2670, 5107 and 6670.
   localparam logic [11:0] MARK_SF1 = 12'h247;
   localparam logic [11:0] MARK_SF2 = 12'h5B8;
   localparam logic [11:0] MARK_SF3 = 12'hA47;
   localparam logic [11:0] MARK_SF4 = 12'hDB8;

   // Marks needed to lock, counting the locking mark itself.
   localparam logic [2:0] LOCK_MARKS_NORMAL = 3'h5;
   localparam logic [2:0] LOCK_MARKS_RELAXED = 3'h3;

   // Mark spacing and the allowed deviation from it.
   localparam int CLK_PERIOD_NS = 8;
   localparam int MARK_SPACING_MS = 1000;
   localparam int MARK_SLACK_US = 1000;
   localparam int MARK_SPACING_CYCLES = MARK_SPACING_MS * 1000000 / CLK_PERIOD_NS;
   localparam int MARK_SLACK_CYCLES = MARK_SLACK_US * 1000 / CLK_PERIOD_NS;
   localparam int TIMER_W = 28;
endpackage

// ===== src/fsc_top.sv
/*
 * Receive-channel control and status: SPI register access to the control
 * and receive status registers, frame sync detection, the receive word
 * queue and its flags, soft flush and loopback steering.
 * Assumes decoded 12-bit words arrive on the system clock domain and that
 * the SPI pins are asynchronous and far slower than the system clock.
 */
// Functional notes
// - Soft flush empties queue, clears sync, drivers off.
// - Soft flush leaves other control bits unchanged.
// - Relaxed mode locks on third ordered mark.
// - Raw capture queues every received word.
// - Raw capture overrides both sync modes.
// - Test bit loops transmit data, disables line.
// - Control bits 7 to 4 read zero.
// - Normal mode needs five ordered marks, one second.
// - Normal lock sets on next spaced first-subframe mark.
// - Relaxed mode starts at any subframe mark.
// - Lock holds until lost, then resynchronises.
// - Without lock only the locking mark is queued, stored kept.
// - Subframe id updates on each queued mark outside raw capture.
// - Full flag when queue holds 32 words.
// - Half flag only at exactly 16 words.
// - Empty flag resets high, clears on store.
// - Store into full queue sets overflow flag, pin.
// - Full queue drops words, keeps contents.
// - Control read 0xE2, write 0x62, one byte.
// - Status read-only, read by 0xE6.
// - SPI mode 0, MSB first.
`timescale 1ns/1ns
`default_nettype none

module fsc_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 32
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_flush,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data,
   output logic [$clog2(DEPTH+1)-1:0] o_count
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [CW-1:0] count_r;
   logic push;
   logic pop;

   assign o_in_ready = (count_r != CW'(DEPTH));
   assign o_out_valid = (count_r != '0);
   assign o_out_data = mem_r[rd_ptr_r];
   assign o_count = count_r;
   assign push = i_in_valid && o_in_ready;
   assign pop = i_out_ready && o_out_valid;

   // Contents are untouched when a push is refused.
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst || i_flush) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
         end
         if (pop) begin
            rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
         end
         count_r <= CW'(count_r + CW'(push) - CW'(pop));
      end
   end
endmodule

module fsc_top #(
   parameter int P_SPACING_CYCLES = fsc_pkg::MARK_SPACING_CYCLES,
   parameter int P_SLACK_CYCLES = fsc_pkg::MARK_SLACK_CYCLES
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_spi_sck,
   input wire logic i_spi_cs_n,
   input wire logic i_spi_mosi,
   output logic o_spi_miso,
   output logic o_spi_miso_oe,
   input wire logic [fsc_pkg::WORD_W-1:0] i_rx_word,
   input wire logic i_rx_word_valid,
   input wire logic i_rx_pop,
   output logic [fsc_pkg::WORD_W-1:0] o_rx_word,
   output logic o_rx_word_valid,
   input wire logic i_receive_decoder_select,
   input wire logic i_tx_biphase_bit,
   input wire logic i_tx_bipolar_rz_bit,
   input wire logic i_line_biphase_bit,
   input wire logic i_line_bipolar_rz_bit,
   output logic o_biphase_sampler_bit,
   output logic o_bipolar_rz_sampler_bit,
   output logic o_line_receiver_en,
   output logic o_line_drivers_en,
   output logic o_lock_indicator,
   output logic o_rx_overflow_pin
);
   localparam int CW = $clog2(fsc_pkg::QUEUE_DEPTH+1);
   localparam int TW = fsc_pkg::TIMER_W;
   localparam logic [TW-1:0] WIN_LO = TW'(P_SPACING_CYCLES - P_SLACK_CYCLES);
   localparam logic [TW-1:0] WIN_HI = TW'(P_SPACING_CYCLES + P_SLACK_CYCLES);

   typedef enum logic [1:0] {SP_OPCODE, SP_WRITE, SP_READ, SP_DONE} fsc_spi_t;

   // ---------------- Control register and its steering ----------------
   logic [fsc_pkg::CTRL_USED_W-1:0] ctrl_r;
   logic ctrl_wr;
   logic [7:0] ctrl_wdata;
   logic flush;
   logic relaxed;
   logic raw;
   logic test;

   assign flush = ctrl_r[fsc_pkg::CB_FLUSH];
   assign relaxed = ctrl_r[fsc_pkg::CB_RELAXED];
   assign raw = ctrl_r[fsc_pkg::CB_RAW];
   assign test = ctrl_r[fsc_pkg::CB_TEST];

   // Only reset and the register write touch these bits; flush never does.
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ctrl_r <= fsc_pkg::CTRL_RESET[fsc_pkg::CTRL_USED_W-1:0];
      end else if (ctrl_wr) begin
         ctrl_r <= ctrl_wdata[fsc_pkg::CTRL_USED_W-1:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_line_receiver_en <= 1'b0;
         o_line_drivers_en <= 1'b0;
         o_biphase_sampler_bit <= 1'b0;
         o_bipolar_rz_sampler_bit <= 1'b0;
      end else begin
         o_line_receiver_en <= !test;
         o_line_drivers_en <= !test && !flush;
         o_biphase_sampler_bit <= (test && !i_receive_decoder_select) ?
            i_tx_biphase_bit : i_line_biphase_bit;
         o_bipolar_rz_sampler_bit <= (test && i_receive_decoder_select) ?
            i_tx_bipolar_rz_bit : i_line_bipolar_rz_bit;
      end
   end

   // ---------------- Sync mark detection ----------------
   logic is_mark;
   logic [1:0] mark_id;
   logic [TW-1:0] timer_r;
   logic [2:0] seq_cnt_r;
   logic [1:0] expect_r;
   logic lock_r;
   logic [1:0] subframe_r;
   logic spaced;
   logic late;
   logic starts;
   logic lock_nxt;
   logic [2:0] need;

   always_comb begin
      is_mark = 1'b1;
      mark_id = 2'h0;
      unique case (i_rx_word)
         fsc_pkg::MARK_SF1: mark_id = 2'h0;
         fsc_pkg::MARK_SF2: mark_id = 2'h1;
         fsc_pkg::MARK_SF3: mark_id = 2'h2;
         fsc_pkg::MARK_SF4: mark_id = 2'h3;
         default: is_mark = 1'b0;
      endcase
   end

   assign spaced = (timer_r >= WIN_LO) && (timer_r <= WIN_HI);
   assign late = (timer_r > WIN_HI);
   assign starts = relaxed || (mark_id == 2'h0);
   assign need = relaxed ? fsc_pkg::LOCK_MARKS_RELAXED : fsc_pkg::LOCK_MARKS_NORMAL;
   assign lock_nxt = !lock_r && i_rx_word_valid && is_mark && spaced
      && (mark_id == expect_r) && (seq_cnt_r != 3'h0)
      && (3'(seq_cnt_r + 1'b1) >= need);

   always_ff @(posedge i_clk) begin
      if (i_rst || flush || raw) begin
         timer_r <= '0;
         seq_cnt_r <= '0;
         expect_r <= '0;
         lock_r <= 1'b0;
      end else begin
         if (!late) begin
            timer_r <= TW'(timer_r + 1'b1);
         end
         if (lock_r) begin
            if (late) begin
               lock_r <= 1'b0;
               seq_cnt_r <= '0;
            end else if (i_rx_word_valid && is_mark && spaced) begin
               if (mark_id == expect_r) begin
                  expect_r <= 2'(expect_r + 1'b1);
                  timer_r <= '0;
               end else begin
                  lock_r <= 1'b0;
                  seq_cnt_r <= '0;
               end
            end
         end else if (i_rx_word_valid && is_mark && spaced && seq_cnt_r != 3'h0
                      && mark_id == expect_r) begin
            seq_cnt_r <= 3'(seq_cnt_r + 1'b1);
            expect_r <= 2'(mark_id + 1'b1);
            timer_r <= '0;
            lock_r <= lock_nxt;
         end else if (i_rx_word_valid && is_mark) begin
            // A misplaced mark restarts the hunt from itself if it may start one, else clears it.
            seq_cnt_r <= starts ? 3'h1 : 3'h0;
            expect_r <= 2'(mark_id + 1'b1);
            timer_r <= '0;
         end else if (late) begin
            seq_cnt_r <= '0;
         end
      end
   end

   // ---------------- Receive queue ----------------
   logic q_in_valid;
   logic q_in_ready;
   logic q_out_valid;
   logic [fsc_pkg::WORD_W-1:0] q_out_data;
   logic [CW-1:0] q_count;
   logic q_pop;

   // Raw capture queues everything; otherwise only the locking mark and words while locked.
   assign q_in_valid = i_rx_word_valid && (raw || lock_r || lock_nxt) && !flush;
   assign q_pop = i_rx_pop && q_out_valid && !flush;

   fsc_fifo #(
      .WIDTH(fsc_pkg::WORD_W),
      .DEPTH(fsc_pkg::QUEUE_DEPTH)
   ) u_rx_queue (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_flush(flush),
      .i_in_valid(q_in_valid),
      .o_in_ready(q_in_ready),
      .i_in_data(i_rx_word),
      .o_out_valid(q_out_valid),
      .i_out_ready(q_pop),
      .o_out_data(q_out_data),
      .o_count(q_count)
   );

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_rx_word <= '0;
         o_rx_word_valid <= 1'b0;
      end else begin
         o_rx_word_valid <= q_pop;
         if (q_pop) begin
            o_rx_word <= q_out_data;
         end
      end
   end

   logic full_r;
   logic half_r;
   logic empty_r;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         full_r <= 1'b0;
         half_r <= 1'b0;
         empty_r <= 1'b1;
      end else begin
         full_r <= (q_count == CW'(fsc_pkg::QUEUE_DEPTH));
         half_r <= (q_count == CW'(fsc_pkg::QUEUE_HALF));
         empty_r <= (q_count == '0) && !(q_in_valid && q_in_ready);
      end
   end

   // Overflow stays set until a hard reset or a soft flush.
   always_ff @(posedge i_clk) begin
      if (i_rst || flush) begin
         o_rx_overflow_pin <= 1'b0;
      end else if (q_in_valid && !q_in_ready) begin
         o_rx_overflow_pin <= 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst || flush) begin
         subframe_r <= '0;
      end else if (q_in_valid && q_in_ready && is_mark && !raw) begin
         subframe_r <= mark_id;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_lock_indicator <= 1'b0;
      end else begin
         o_lock_indicator <= lock_r;
      end
   end

   logic [7:0] status;

   always_comb begin
      status = '0;
      status[fsc_pkg::SB_LOCK] = lock_r;
      status[fsc_pkg::SB_ID_HI:fsc_pkg::SB_ID_LO] = subframe_r;
      status[fsc_pkg::SB_FULL] = full_r;
      status[fsc_pkg::SB_HALF] = half_r;
      status[fsc_pkg::SB_EMPTY] = empty_r;
      status[fsc_pkg::SB_OVF] = o_rx_overflow_pin;
   end

   // ---------------- SPI slave, mode 0 ----------------
   logic [2:0] sck_s_r;
   logic [2:0] cs_s_r;
   logic [2:0] mosi_s_r;
   logic sck_f_r;
   logic cs_f_r;
   logic sck_rise;
   logic sck_fall;
   logic mosi_bit;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         sck_s_r <= '0;
         cs_s_r <= '1;
         mosi_s_r <= '0;
         sck_f_r <= 1'b0;
         cs_f_r <= 1'b1;
      end else begin
         sck_s_r <= {sck_s_r[1:0], i_spi_sck};
         cs_s_r <= {cs_s_r[1:0], i_spi_cs_n};
         mosi_s_r <= {mosi_s_r[1:0], i_spi_mosi};
         if (sck_s_r[1] == sck_s_r[2]) begin
            sck_f_r <= sck_s_r[2];
         end
         if (cs_s_r[1] == cs_s_r[2]) begin
            cs_f_r <= cs_s_r[2];
         end
      end
   end

   assign sck_rise = (sck_s_r[1] == sck_s_r[2]) && sck_s_r[2] && !sck_f_r;
   assign sck_fall = (sck_s_r[1] == sck_s_r[2]) && !sck_s_r[2] && sck_f_r;
   assign mosi_bit = mosi_s_r[2];

   fsc_spi_t spi_state_r;
   logic [7:0] shift_r;
   logic [2:0] bit_cnt_r;
   logic [7:0] tx_r;
   logic tx_armed_r;

   assign ctrl_wr = (spi_state_r == SP_WRITE) && sck_rise && !cs_f_r
      && (bit_cnt_r == 3'(fsc_pkg::SPI_BITS - 1));
   assign ctrl_wdata = {shift_r[6:0], mosi_bit};

   always_ff @(posedge i_clk) begin
      if (i_rst || cs_f_r) begin
         spi_state_r <= SP_OPCODE;
         shift_r <= '0;
         bit_cnt_r <= '0;
         tx_r <= '0;
         tx_armed_r <= 1'b0;
         o_spi_miso <= 1'b0;
         o_spi_miso_oe <= 1'b0;
      end else begin
         if (sck_rise) begin
            shift_r <= {shift_r[6:0], mosi_bit};
            bit_cnt_r <= 3'(bit_cnt_r + 1'b1);
            if (bit_cnt_r == 3'(fsc_pkg::SPI_BITS - 1)) begin
               unique case (spi_state_r)
                  SP_OPCODE: begin
                     unique case ({shift_r[6:0], mosi_bit})
                        fsc_pkg::OP_CTRL_WR: spi_state_r <= SP_WRITE;
                        fsc_pkg::OP_CTRL_RD: begin
                           spi_state_r <= SP_READ;
                           tx_r <= {{(8-fsc_pkg::CTRL_USED_W){1'b0}}, ctrl_r};
                           tx_armed_r <= 1'b1;
                        end
                        fsc_pkg::OP_STAT_RD: begin
                           spi_state_r <= SP_READ;
                           tx_r <= status;
                           tx_armed_r <= 1'b1;
                        end
                        default: spi_state_r <= SP_DONE;
                     endcase
                  end
                  SP_WRITE: spi_state_r <= SP_DONE;
                  SP_READ: spi_state_r <= SP_DONE;
                  SP_DONE: spi_state_r <= SP_DONE;
               endcase
            end
         end
         if (sck_fall) begin
            if (spi_state_r == SP_READ) begin
               o_spi_miso <= tx_r[7];
               o_spi_miso_oe <= 1'b1;
               tx_r <= {tx_r[6:0], 1'b0};
               tx_armed_r <= 1'b0;
            end else if (!tx_armed_r) begin
               o_spi_miso_oe <= 1'b0;
            end
         end
      end
   end
endmodule

`default_nettype wire

// ===== test/fsc_top_monitor.sv
/*
 * Concurrent checks on the ports of fsc_top, bound into every instance.
 * Assumes one clock and the synchronous active-high reset of fsc_top.
 */
`timescale 1ns/1ns
`default_nettype none
module fsc_top_monitor (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_spi_sck,
   input wire logic i_spi_cs_n,
   input wire logic o_spi_miso,
   input wire logic o_spi_miso_oe,
   input wire logic i_rx_word_valid,
   input wire logic i_rx_pop,
   input wire logic o_rx_word_valid,
   input wire logic i_receive_decoder_select,
   input wire logic i_tx_biphase_bit,
   input wire logic i_line_biphase_bit,
   input wire logic o_biphase_sampler_bit,
   input wire logic o_line_receiver_en,
   input wire logic o_line_drivers_en,
   input wire logic o_lock_indicator,
   input wire logic o_rx_overflow_pin
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   a_pop_to_valid: assert property (o_rx_word_valid |-> $past(i_rx_pop))
      else $error("word valid without pop");
   a_ovf_cause: assert property ($rose(o_rx_overflow_pin) |->
      $past(i_rx_word_valid) || $past(i_rx_word_valid, 2)) else $error("overflow without word");
   a_lock_cause: assert property ($rose(o_lock_indicator) |->
      $past(i_rx_word_valid, 2)) else $error("lock without mark");
   a_test_drivers_off: assert property (!o_line_receiver_en && !$past(i_rst) |->
      !o_line_drivers_en) else $error("drivers on in test mode");
   a_loop_data: assert property (!o_line_receiver_en && !$past(o_line_receiver_en)
      && !$past(i_rst) && !$past(i_receive_decoder_select)
      |-> o_biphase_sampler_bit == $past(i_tx_biphase_bit)) else $error("loopback data");
   a_line_data: assert property (o_line_receiver_en && $past(o_line_receiver_en)
      && !$past(i_receive_decoder_select)
      |-> o_biphase_sampler_bit == $past(i_line_biphase_bit)) else $error("line data");
   a_oe_needs_cs: assert property ($rose(o_spi_miso_oe) |-> !i_spi_cs_n)
      else $error("miso driven without select");
   a_oe_release: assert property ($rose(i_spi_cs_n) |-> ##[1:6] !o_spi_miso_oe)
      else $error("miso not released");
   a_miso_on_low: assert property (o_spi_miso_oe && $past(o_spi_miso_oe)
      && $changed(o_spi_miso) |-> !i_spi_sck) else $error("miso changed with clock high");
endmodule
bind fsc_top fsc_top_monitor mon_u (.*);
`default_nettype wire

// ===== test/fsc_spi_host.sv
/*
 * Behavioural SPI mode 0 host that runs one instruction per call of xfer.
 * Assumes the system clock; the serial clock stands low outside transfers.
 */
`timescale 1ns/1ns
`default_nettype none
module fsc_spi_host (
   input wire logic i_clk,
   output logic o_sck,
   output logic o_cs_n,
   output logic o_mosi,
   input wire logic i_miso,
   input wire logic i_miso_oe,
   output logic o_saw_oe
);
   logic last_r;
   initial begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_mosi = 1'b0;
      o_saw_oe = 1'b0;
      last_r = 1'b0;
   end
   // A released data line is read as the inverse of its last driven level.
   always @(posedge i_clk) begin
      if (i_miso_oe) begin
         last_r <= i_miso;
         o_saw_oe <= 1'b1;
      end
   end
   task automatic xfer(input logic [7:0] op, input logic [7:0] wd, output logic [7:0] rd);
      logic [15:0] sh;
      sh = {op, wd};
      rd = 8'h00;
      o_saw_oe <= 1'b0;
      @(posedge i_clk) o_cs_n <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         @(posedge i_clk) o_mosi <= sh[15-i];
         repeat (7) @(posedge i_clk);
         o_sck <= 1'b1;
         if (i > 7) rd[15-i] = i_miso_oe ? i_miso : ~last_r;
         repeat (8) @(posedge i_clk);
         o_sck <= 1'b0;
      end
      repeat (8) @(posedge i_clk);
      o_cs_n <= 1'b1;
      repeat (8) @(posedge i_clk);
   endtask
endmodule
`default_nettype wire

// ===== test/frame_sync_control_status_tb.sv
/*
 * Self-checking bench for fsc_top: SPI register access, raw fill,
 * loopback, soft flush, normal and relaxed lock.
 * Assumes fsc_top_monitor is bound in and the mark spacing is shortened.
 */
`timescale 1ns/1ns
`default_nettype none
module frame_sync_control_status_tb;
   localparam int SP = 2000;
   localparam logic [7:0] ST = fsc_pkg::OP_STAT_RD;
   localparam logic [7:0] CR = fsc_pkg::OP_CTRL_RD;
   logic i_clk, i_rst, i_spi_sck, i_spi_cs_n, i_spi_mosi, o_spi_miso, o_spi_miso_oe;
   logic i_rx_word_valid, i_rx_pop, o_rx_word_valid, i_receive_decoder_select;
   logic i_tx_biphase_bit, i_tx_bipolar_rz_bit, i_line_biphase_bit, i_line_bipolar_rz_bit;
   logic o_biphase_sampler_bit, o_bipolar_rz_sampler_bit, o_line_receiver_en;
   logic o_line_drivers_en, o_lock_indicator, o_rx_overflow_pin, saw_oe, s;
   logic [11:0] i_rx_word, o_rx_word, w;
   logic [11:0] mk [4];
   logic [7:0] rd;
   logic [11:0] exp_q[$];
   int error_cnt, n_checks, seed;
   fsc_top #(.P_SPACING_CYCLES(SP), .P_SLACK_CYCLES(2)) dut_u (.*);
   fsc_spi_host host_u (.i_clk(i_clk), .o_sck(i_spi_sck), .o_cs_n(i_spi_cs_n),
      .o_mosi(i_spi_mosi), .i_miso(o_spi_miso), .i_miso_oe(o_spi_miso_oe), .o_saw_oe(saw_oe));
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Builds the status byte that a given sync state and queue fill should read back.
   function automatic logic [7:0] stat_exp(input logic lk, input logic [1:0] id, input int n,
      input logic ov);
      stat_exp = 8'h00;
      stat_exp[fsc_pkg::SB_LOCK] = lk;
      stat_exp[fsc_pkg::SB_ID_HI:fsc_pkg::SB_ID_LO] = id;
      stat_exp[fsc_pkg::SB_FULL] = (n == fsc_pkg::QUEUE_DEPTH);
      stat_exp[fsc_pkg::SB_HALF] = (n == fsc_pkg::QUEUE_HALF);
      stat_exp[fsc_pkg::SB_EMPTY] = (n == 0);
      stat_exp[fsc_pkg::SB_OVF] = ov;
   endfunction
   task automatic wr(input logic [7:0] v);
      host_u.xfer(fsc_pkg::OP_CTRL_WR, v, rd);
   endtask
   task automatic rds(input logic [7:0] op, input logic [7:0] m, input logic [7:0] e);
      host_u.xfer(op, 8'h00, rd);
      check({4'h0, rd & m}, {4'h0, e});
   endtask
   task automatic pulse(input logic [11:0] v);
      @(posedge i_clk) begin
         i_rx_word_valid <= 1'b1;
         i_rx_word <= v;
      end
      @(posedge i_clk) i_rx_word_valid <= 1'b0;
   endtask
   // Sends a mark exactly SP cycles after the previous pulse, checking lock first.
   task automatic mark(input logic [11:0] m, input logic l);
      repeat (SP - 2) @(posedge i_clk);
      check(12'(o_lock_indicator), 12'(l));
      pulse(m);
   endtask
   task automatic wait_lock(input logic v, input int n);
      int k;
      for (k = 0; k < n && o_lock_indicator !== v; k++) @(negedge i_clk);
      check(12'(o_lock_indicator), 12'(v));
      if (k == n) close_out();
   endtask
   task automatic drain(input int n);
      int k;
      for (int i = 0; i < n; i++) begin
         @(posedge i_clk) i_rx_pop <= 1'b1;
         @(posedge i_clk) i_rx_pop <= 1'b0;
         for (k = 0; k < 4 && o_rx_word_valid !== 1'b1; k++) @(negedge i_clk);
         check(o_rx_word, exp_q.pop_front());
         if (k == 4) begin
            error_cnt++;
            close_out();
         end
      end
   endtask
   initial begin
      repeat (90000) @(posedge i_clk);
      error_cnt++;
      close_out();
   end
   initial begin
      mk = '{fsc_pkg::MARK_SF1, fsc_pkg::MARK_SF2, fsc_pkg::MARK_SF3, fsc_pkg::MARK_SF4};
      seed = 32'h4F30;
      error_cnt = 0;
      n_checks = 0;
      i_rst = 1'b1;
      {i_rx_pop, i_rx_word_valid, i_rx_word, i_receive_decoder_select} = 15'h0000;
      {i_tx_biphase_bit, i_tx_bipolar_rz_bit, i_line_biphase_bit, i_line_bipolar_rz_bit} = 4'h0;
      repeat (4) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (4) @(posedge i_clk);
      rds(ST, 8'hFF, 8'h04);
      rds(CR, 8'hFF, 8'h00);
      w = 12'($random(seed));
      wr({w[7:4], 4'h6});
      rds(CR, 8'hFF, 8'h06);
      for (int i = 0; i < 33; i++) begin
         w = 12'($random(seed));
         pulse(w);
         if (i < 32) exp_q.push_back(w);
         if (i == 15) rds(ST, 8'hFF, stat_exp(1'b0, 2'h0, 16, 1'b0));
         if (i == 16) rds(ST, 8'hFF, stat_exp(1'b0, 2'h0, 17, 1'b0));
         if (i == 31) rds(ST, 8'hFF, stat_exp(1'b0, 2'h0, 32, 1'b0));
      end
      // The overflow pin is registered on the edge that refuses the word.
      @(negedge i_clk);
      check(12'(o_rx_overflow_pin), 12'h001);
      rds(ST, 8'hFF, stat_exp(1'b0, 2'h0, 32, 1'b1));
      drain(32);
      rds(ST, 8'hFF, stat_exp(1'b0, 2'h0, 0, 1'b1));
      host_u.xfer(8'hE4, 8'h00, rd);
      check(12'(saw_oe), 12'h000);
      $display("test raw fill done");
      @(posedge i_clk) i_receive_decoder_select <= 1'($random(seed));
      wr(8'h01);
      for (int i = 0; i < 6; i++) begin
         // Alternate the sampler choice so that both loopback targets are exercised.
         @(posedge i_clk) {i_receive_decoder_select, i_tx_biphase_bit, i_tx_bipolar_rz_bit,
            i_line_biphase_bit, i_line_bipolar_rz_bit} <= {1'(i), 4'($random(seed))};
         repeat (2) @(negedge i_clk);
         s = i_receive_decoder_select;
         check(12'(s ? o_bipolar_rz_sampler_bit : o_biphase_sampler_bit),
            12'(s ? i_tx_bipolar_rz_bit : i_tx_biphase_bit));
      end
      check(12'({o_line_receiver_en, o_line_drivers_en}), 12'h000);
      $display("test loopback done");
      wr(8'h0E);
      pulse(12'h0FF);
      rds(CR, 8'hFF, 8'h0E);
      rds(ST, 8'hFF, 8'h04);
      check(12'(o_line_drivers_en), 12'h000);
      wr(8'h00);
      check(12'({o_line_receiver_en, o_line_drivers_en}), 12'h003);
      check(12'({o_biphase_sampler_bit, o_bipolar_rz_sampler_bit}),
         12'({i_line_biphase_bit, i_line_bipolar_rz_bit}));
      $display("test flush done");
      for (int i = 0; i < 5; i++) mark(mk[i % 4], 1'b0);
      wait_lock(1'b1, 4);
      fork
         mark(mk[1], 1'b1);
         rds(ST, 8'hFF, 8'h80);
      join
      rds(ST, 8'hFF, 8'hA0);
      exp_q.push_back(mk[0]);
      exp_q.push_back(mk[1]);
      drain(2);
      wait_lock(1'b0, SP + 10);
      pulse(12'($random(seed)) & 12'h0FF);
      rds(ST, 8'h9F, 8'h04);
      $display("test normal lock done");
      wr(8'h04);
      for (int i = 1; i < 4; i++) mark(mk[i], 1'b0);
      wait_lock(1'b1, 4);
      rds(ST, 8'hFF, 8'hE0);
      $display("test relaxed lock done");
      close_out();
   end
endmodule
`default_nettype wire
